// [design/irq_addr_pkg.sv]
package irq_addr_pkg;
	// Register offsets on the plain register port (word index)
	localparam logic [3:0]  OFF_HP_CAUSE     = 4'h8;
	localparam logic [3:0]  OFF_STD_ENABLE   = 4'h9;
	localparam logic [3:0]  OFF_TERM_ADDR    = 4'hA;
	localparam logic [3:0]  OFF_HP_ENABLE    = 4'h7;
	localparam logic [3:0]  OFF_ROLE_CTRL    = 4'h0;
	localparam logic [3:0]  OFF_CORE_STATUS  = 4'h1;

	// High-priority cause / enable bit positions
	localparam int HP_STD      = 0;
	localparam int HP_MSGERR   = 1;
	localparam int HP_CBEND    = 2;
	localparam int HP_STFAIL   = 3;
	localparam int HP_STEND    = 4;
	localparam int HP_SSFAIL   = 5;
	localparam int HP_DBC      = 6;
	localparam int HP_ILLOG    = 7;
	localparam int HP_OVERRUN  = 8;
	localparam logic [15:0] HP_MASK = 16'h01FF;

	// Standard event enable bit positions
	localparam int SE_ICONT    = 0;
	localparam int SE_MSGERR   = 1;
	localparam int SE_RETRY    = 2;
	localparam int SE_POLL     = 3;
	localparam int SE_ILLCMD   = 4;
	localparam int SE_ILLBCAST = 5;
	localparam logic [15:0] SE_MASK = 16'h003F;

	// Terminal address register fields
	localparam int TA_ADDR_LSB = 0;
	localparam int TA_PARITY   = 5;
	localparam int TA_PERR     = 6;
	localparam int TA_LOCK     = 7;
	localparam int TA_ROLE     = 8;
	localparam int TA_BUSYINH  = 9;
	localparam int TA_SRQ      = 10;
	localparam int TA_TFLAG    = 11;
	localparam int TA_DBCA     = 12;
	localparam int TA_SSF      = 13;
	localparam int TA_BUSY     = 14;
	localparam int TA_INSTR    = 15;
	localparam logic [15:0] TA_WR_MASK = 16'hFE3F;

	// Role control register: bit 10 software role override value
	localparam int RC_ROLE     = 10;
	localparam logic [15:0] RC_MASK = 16'h0400;

	// Core status register: bit 0 halted
	localparam int CS_HALTED   = 0;

	localparam logic [15:0] RESET_ZERO = 16'h0000;
endpackage : irq_addr_pkg

// [design/irq_addr_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module irq_addr_regs (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic [15:0] hp_event,
	input  wire logic        ev_illegal_bcast,
	input  wire logic        ev_illegal_cmd,
	input  wire logic        ev_poll_match,
	input  wire logic        ev_poll_cb_enable,
	input  wire logic        ev_retry_fail_all,
	input  wire logic        ev_msg_error,
	input  wire logic        ev_int_continue,
	input  wire logic        ev_descriptor_irq,
	input  wire logic        ev_dbc_mode_code,
	input  wire logic        ev_selftest_fail,
	input  wire logic        lock_pin,
	input  wire logic        role_select_pin,
	input  wire logic [4:0]  terminal_address_pins,
	input  wire logic        terminal_address_parity_pin,
	output logic             hp_irq_out,
	output logic             standard_irq_out_n,
	output logic             halted,
	output logic             controller_role,
	output logic             sw_instr,
	output logic             sw_busy,
	output logic             sw_ssflag,
	output logic             sw_ssf_log,
	output logic             sw_dbc_accept,
	output logic             sw_tflag,
	output logic             sw_srq,
	output logic             subsys_xfer_inhibit,
	output logic [4:0]       terminal_address
);

	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_RUN  = 2'b01
	} init_state_t;

	init_state_t init_r;
	logic [15:0] hp_cause_r;
	logic [15:0] hp_enable_r;
	logic [15:0] std_enable_r;
	logic [15:0] taddr_r;
	logic [15:0] role_ctrl_r;
	logic        halt_r;
	logic        lock_r;
	logic        rsel_r;
	logic [15:0] hp_set;
	logic        std_irq;
	logic        terminal_mode;

	function automatic logic odd_ok(input logic [5:0] a);
		odd_ok = ^a;
	endfunction : odd_ok

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction : hit

	assign terminal_mode = ~role_ctrl_r[irq_addr_pkg::RC_ROLE];

	// Standard interrupt sources gated by enable, four also by mode; descriptor interrupt passes ungated
	always_comb begin
		std_irq = ev_descriptor_irq;
		if (terminal_mode) begin
			std_irq = std_irq | (std_enable_r[irq_addr_pkg::SE_ILLBCAST] & ev_illegal_bcast);
			std_irq = std_irq | (std_enable_r[irq_addr_pkg::SE_ILLCMD] & ev_illegal_cmd);
		end else begin
			std_irq = std_irq | (std_enable_r[irq_addr_pkg::SE_POLL] & ev_poll_match
				& ev_poll_cb_enable);
			std_irq = std_irq | (std_enable_r[irq_addr_pkg::SE_RETRY] & ev_retry_fail_all);
		end
		std_irq = std_irq | (std_enable_r[irq_addr_pkg::SE_MSGERR] & ev_msg_error);
		std_irq = std_irq | (std_enable_r[irq_addr_pkg::SE_ICONT] & ev_int_continue);
	end

	// High-priority set terms; bit 0 only comes from standard interrupts
	always_comb begin
		hp_set = hp_event & hp_enable_r & irq_addr_pkg::HP_MASK;
		hp_set[irq_addr_pkg::HP_STD] = std_irq & hp_enable_r[irq_addr_pkg::HP_STD];
	end

	// Set wins over a simultaneous write-one clear
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			hp_cause_r <= irq_addr_pkg::RESET_ZERO;
		end else if (reg_wr && hit(reg_addr, irq_addr_pkg::OFF_HP_CAUSE)) begin
			hp_cause_r <= ((hp_cause_r & ~reg_wdata) | hp_set) & irq_addr_pkg::HP_MASK;
		end else begin
			hp_cause_r <= hp_cause_r | hp_set;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			hp_enable_r <= irq_addr_pkg::RESET_ZERO;
		end else if (reg_wr && hit(reg_addr, irq_addr_pkg::OFF_HP_ENABLE)) begin
			hp_enable_r <= reg_wdata & irq_addr_pkg::HP_MASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			std_enable_r <= irq_addr_pkg::RESET_ZERO;
		end else if (reg_wr && hit(reg_addr, irq_addr_pkg::OFF_STD_ENABLE)) begin
			std_enable_r <= reg_wdata & irq_addr_pkg::SE_MASK;
		end
	end

	// Pin mirrors sampled every cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			lock_r <= 1'b0;
			rsel_r <= 1'b0;
		end else begin
			lock_r <= lock_pin;
			rsel_r <= role_select_pin;
		end
	end

	// Role: loaded from the pin after reset, software may override unless locked
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			role_ctrl_r <= irq_addr_pkg::RESET_ZERO;
		end else if (init_r == ST_LOAD) begin
			role_ctrl_r <= {5'h00, role_select_pin, 10'h000};
		end else if (reg_wr && hit(reg_addr, irq_addr_pkg::OFF_ROLE_CTRL) && !lock_r) begin
			role_ctrl_r <= reg_wdata & irq_addr_pkg::RC_MASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			init_r <= ST_LOAD;
		end else begin
			init_r <= ST_RUN;
		end
	end

	// Address pins caught on the first clock after reset release, not under reset
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			taddr_r <= irq_addr_pkg::RESET_ZERO;
		end else if (init_r == ST_LOAD) begin
			taddr_r[5:0] <= {terminal_address_parity_pin, terminal_address_pins};
			taddr_r[irq_addr_pkg::TA_PERR] <= ~odd_ok({terminal_address_parity_pin,
				terminal_address_pins});
		end else if (reg_wr && hit(reg_addr, irq_addr_pkg::OFF_TERM_ADDR)) begin
			taddr_r[15:9] <= reg_wdata[15:9];
			if (!lock_r) begin
				taddr_r[5:0] <= reg_wdata[5:0];
				taddr_r[irq_addr_pkg::TA_PERR] <= ~odd_ok(reg_wdata[5:0]);
			end
		end
	end

	// Halt on enabled message error until its cause bit is written clear
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			halt_r <= 1'b0;
		end else if (hp_set[irq_addr_pkg::HP_MSGERR]) begin
			halt_r <= 1'b1;
		end else if (reg_wr && hit(reg_addr, irq_addr_pkg::OFF_HP_CAUSE)
			&& reg_wdata[irq_addr_pkg::HP_MSGERR]) begin
			halt_r <= 1'b0;
		end
	end

	// Interrupt outputs follow the registered causes one cycle later
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			hp_irq_out         <= 1'b0;
			standard_irq_out_n <= 1'b1;
		end else begin
			hp_irq_out <= |(hp_cause_r & hp_enable_r & irq_addr_pkg::HP_MASK
				& ~16'h0001);
			standard_irq_out_n <= ~(hp_cause_r[irq_addr_pkg::HP_STD]
				& hp_enable_r[irq_addr_pkg::HP_STD]);
		end
	end

	// Status word controls to the protocol engine
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			halted              <= 1'b0;
			controller_role     <= 1'b0;
			sw_instr            <= 1'b0;
			sw_busy             <= 1'b0;
			sw_ssflag           <= 1'b0;
			sw_ssf_log          <= 1'b0;
			sw_dbc_accept       <= 1'b0;
			sw_tflag            <= 1'b0;
			sw_srq              <= 1'b0;
			subsys_xfer_inhibit <= 1'b0;
			terminal_address    <= 5'h00;
		end else begin
			halted          <= halt_r;
			controller_role <= role_ctrl_r[irq_addr_pkg::RC_ROLE];
			sw_instr        <= taddr_r[irq_addr_pkg::TA_INSTR];
			sw_busy         <= taddr_r[irq_addr_pkg::TA_BUSY]
				| taddr_r[irq_addr_pkg::TA_BUSYINH];
			sw_ssflag       <= taddr_r[irq_addr_pkg::TA_SSF];
			sw_ssf_log      <= taddr_r[irq_addr_pkg::TA_SSF] & terminal_mode;
			sw_dbc_accept   <= taddr_r[irq_addr_pkg::TA_DBCA] & ev_dbc_mode_code;
			sw_tflag        <= taddr_r[irq_addr_pkg::TA_TFLAG] | ev_selftest_fail;
			sw_srq          <= taddr_r[irq_addr_pkg::TA_SRQ];
			subsys_xfer_inhibit <= taddr_r[irq_addr_pkg::TA_BUSYINH];
			terminal_address <= taddr_r[4:0];
		end
	end

	// Read port, data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reg_rdata <= irq_addr_pkg::RESET_ZERO;
		end else if (reg_rd) begin
			unique case (reg_addr)
				irq_addr_pkg::OFF_HP_CAUSE:    reg_rdata <= hp_cause_r;
				irq_addr_pkg::OFF_HP_ENABLE:   reg_rdata <= hp_enable_r;
				irq_addr_pkg::OFF_STD_ENABLE:  reg_rdata <= std_enable_r;
				irq_addr_pkg::OFF_TERM_ADDR:   reg_rdata <= {taddr_r[15:9], rsel_r, lock_r,
					taddr_r[6:0]};
				irq_addr_pkg::OFF_ROLE_CTRL:   reg_rdata <= role_ctrl_r;
				irq_addr_pkg::OFF_CORE_STATUS: reg_rdata <= {15'h0000, halt_r};
				default:                       reg_rdata <= irq_addr_pkg::RESET_ZERO;
			endcase
		end else begin
			reg_rdata <= irq_addr_pkg::RESET_ZERO;
		end
	end

endmodule : irq_addr_regs
`default_nettype wire

// [verification/irq_addr_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module irq_addr_chk (
	input wire logic        clk_sys,
	input wire logic        srst,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [15:0] hp_event,
	input wire logic        lock_pin,
	input wire logic        role_select_pin,
	input wire logic        hp_irq_out,
	input wire logic        halted,
	input wire logic        sw_busy,
	input wire logic        sw_srq,
	input wire logic        subsys_xfer_inhibit,
	input wire logic [4:0]  terminal_address
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read");
	AST_CAUSE_RSVD: assert property ($past(reg_rd) && $past(reg_addr) == irq_addr_pkg::OFF_HP_CAUSE
		|-> reg_rdata[15:9] == 7'h00) else $error("reserved cause bits set");
	AST_SEN_RSVD: assert property ($past(reg_rd) && $past(reg_addr) == irq_addr_pkg::OFF_STD_ENABLE
		|-> reg_rdata[15:6] == 10'h000) else $error("reserved enable bits set");
	AST_LOCK_RO: assert property (reg_rd && reg_addr == irq_addr_pkg::OFF_TERM_ADDR &&
		$stable(lock_pin) && lock_pin == $past(lock_pin, 2) |=> reg_rdata[7] == $past(lock_pin))
		else $error("lock bit does not follow its pin");
	AST_ROLE_RO: assert property (reg_rd && reg_addr == irq_addr_pkg::OFF_TERM_ADDR &&
		$stable(role_select_pin) |=> reg_rdata[8] == $past(role_select_pin))
		else $error("role bit does not follow its pin");
	AST_ADDR_HOLD: assert property (reg_wr && reg_addr == irq_addr_pkg::OFF_TERM_ADDR &&
		lock_pin && $past(lock_pin) |=> $stable(terminal_address) [*2])
		else $error("address changed while locked");
	AST_HALT_REL: assert property (reg_wr && reg_addr == irq_addr_pkg::OFF_HP_CAUSE &&
		reg_wdata[1] && !hp_event[1] ##1 !hp_event[1] |=> !halted) else $error("halt not released");
	AST_HP_FALL: assert property ($fell(hp_irq_out) |-> $past(reg_wr, 2))
		else $error("interrupt dropped without a write");
	AST_INH_BUSY: assert property (subsys_xfer_inhibit |-> sw_busy)
		else $error("inhibit without busy");
	AST_SRQ: assert property (reg_wr && reg_addr == irq_addr_pkg::OFF_TERM_ADDR
		|=> ##1 sw_srq == $past(reg_wdata[10], 2)) else $error("service request wrong");
endmodule : irq_addr_chk
bind irq_addr_regs irq_addr_chk u_chk (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .hp_event, .lock_pin, .role_select_pin, .hp_irq_out, .halted, .sw_busy, .sw_srq,
	.subsys_xfer_inhibit, .terminal_address);
`default_nettype wire

// [verification/engine_model.sv]
`timescale 1ns/10ps
`default_nettype none
module engine_model (
	input  wire logic        clk_sys,
	output logic      [15:0] hp_event,
	output logic      [9:0]  ev
);
	initial begin
		hp_event = 16'h0000;
		ev = 10'h000;
	end
	// One-cycle event pulse; the caller sets the command block enable beside a poll match
	task automatic fire(input logic [15:0] h, input logic [9:0] e);
		@(posedge clk_sys);
		hp_event <= h;
		ev <= e;
		@(posedge clk_sys);
		hp_event <= 16'h0000;
		ev <= 10'h000;
	endtask : fire
endmodule : engine_model
`default_nettype wire

// [verification/irq_status_and_rt_address_regs_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module irq_status_and_rt_address_regs_tb;
	localparam logic [3:0] A_CAUSE = irq_addr_pkg::OFF_HP_CAUSE;
	localparam logic [3:0] A_SEN = irq_addr_pkg::OFF_STD_ENABLE;
	localparam logic [3:0] A_TA = irq_addr_pkg::OFF_TERM_ADDR;
	localparam logic [3:0] A_ROLE = irq_addr_pkg::OFF_ROLE_CTRL;
	localparam logic [5:0][9:0] EVS = {10'h020, 10'h040, 10'h010, 10'h00C, 10'h002, 10'h001};
	localparam logic [5:0] CTL = 6'h1C;
	logic clk_sys, srst, reg_wr, reg_rd, lock_pin, role_select_pin, terminal_address_parity_pin;
	logic hp_irq_out, standard_irq_out_n, halted, controller_role, sw_instr, sw_busy, sw_ssflag;
	logic sw_ssf_log, sw_dbc_accept, sw_tflag, sw_srq, subsys_xfer_inhibit;
	logic [3:0]  reg_addr;
	logic [4:0]  terminal_address_pins, terminal_address;
	logic [9:0]  ev;
	logic [15:0] reg_wdata, reg_rdata, hp_event, v;
	int          fail_count, check_count;
	int          cycles = 0;
	engine_model eng (.clk_sys, .hp_event, .ev);
	irq_addr_regs dut (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.hp_event, .ev_illegal_bcast(ev[0]), .ev_illegal_cmd(ev[1]), .ev_poll_match(ev[2]),
		.ev_poll_cb_enable(ev[3]), .ev_retry_fail_all(ev[4]), .ev_msg_error(ev[5]),
		.ev_int_continue(ev[6]), .ev_descriptor_irq(ev[7]), .ev_dbc_mode_code(ev[8]),
		.ev_selftest_fail(ev[9]), .lock_pin, .role_select_pin, .terminal_address_pins,
		.terminal_address_parity_pin, .hp_irq_out, .standard_irq_out_n, .halted,
		.controller_role, .sw_instr, .sw_busy, .sw_ssflag, .sw_ssf_log, .sw_dbc_accept,
		.sw_tflag, .sw_srq, .subsys_xfer_inhibit, .terminal_address);
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : settle
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fail_count++;
			close_out();
		end
	end
	initial begin
		{srst, reg_wr, reg_rd, reg_addr, reg_wdata, lock_pin} = {1'b1, 23'h0};
		{role_select_pin, terminal_address_pins, terminal_address_parity_pin} = 7'h2A;
		{fail_count, check_count} = '0;
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rd(A_TA, v); chk(v, 16'h0015);
		rd(A_CAUSE, v); chk(v, 16'h0000);
		wr(A_SEN, 16'hFFFF);
		rd(A_SEN, v); chk(v, 16'h003F);
		wr(irq_addr_pkg::OFF_HP_ENABLE, 16'h01FF);
		for (int k = 1; k < 9; k++) begin
			eng.fire(16'h0001 << k, 10'h000);
			settle();
			rd(A_CAUSE, v); chk(v, 16'h0001 << k);
			chk({15'h0000, halted}, {15'h0000, k == 1});
			wr(A_CAUSE, 16'h0000);
			settle();
			chk({15'h0000, hp_irq_out}, 16'h0001);
			wr(A_CAUSE, 16'h0001 << k);
			settle();
			chk({14'h0000, hp_irq_out, halted}, 16'h0000);
		end
		// Each standard event but the descriptor interrupt, in the role that owns it
		for (int i = 0; i < 6; i++) begin
			wr(A_ROLE, CTL[i] ? 16'h0400 : 16'h0000);
			eng.fire(16'h0000, EVS[i]);
			settle();
			rd(A_CAUSE, v); chk(v, 16'h0001);
			chk({15'h0000, standard_irq_out_n}, 16'h0000);
			wr(A_CAUSE, 16'h0001);
			settle();
			chk({15'h0000, standard_irq_out_n}, 16'h0001);
		end
		// Poll match without the command block bit must stay silent in controller role
		wr(A_ROLE, 16'h0400);
		eng.fire(16'h0000, 10'h004);
		settle();
		rd(A_CAUSE, v); chk(v, 16'h0000);
		wr(A_ROLE, 16'h0000);
		wr(A_TA, 16'h0023);
		rd(A_TA, v); chk(v, 16'h0023);
		wr(A_TA, 16'h0003);
		rd(A_TA, v); chk(v, 16'h0043);
		wr(A_TA, 16'hEE03);
		settle();
		chk({sw_instr, sw_busy, sw_ssflag, sw_ssf_log, sw_tflag, sw_srq,
			subsys_xfer_inhibit}, 16'h007F);
		wr(A_TA, 16'h5003);
		eng.fire(16'h0000, 10'h100);
		#1;
		chk({sw_busy, subsys_xfer_inhibit, sw_dbc_accept}, 16'h0005);
		eng.fire(16'h0000, 10'h200);
		#1;
		chk({15'h0000, sw_tflag}, 16'h0001);
		@(posedge clk_sys);
		lock_pin <= 1'b1;
		settle();
		wr(A_TA, 16'h001F);
		wr(A_ROLE, 16'h0400);
		settle();
		rd(A_TA, v); chk(v, 16'h00C3);
		chk({10'h000, controller_role, terminal_address}, 16'h0003);
		rd(4'hF, v); chk(v, 16'h0000);
		close_out();
	end
endmodule : irq_status_and_rt_address_regs_tb
`default_nettype wire
